// ==== design/usc_pkg.sv ====
/*
 Package of the serial port control block: register map, field positions,
 reset values, frame constants and state codes.
 Assumes a 100 MHz system clock and a plain strobe register port.
*/
package usc_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [1:0] USC_ADDR_CTRL = 2'h0;
    localparam logic [1:0] USC_ADDR_DATA = 2'h1;
    localparam logic [1:0] USC_ADDR_MASK = 2'h2;
    localparam logic [1:0] USC_ADDR_DIV = 2'h3;
    // ------------------------------------------------------------
    // Control field positions
    // ------------------------------------------------------------
    localparam int USC_B_FMT = 7;
    localparam int USC_B_UNUSED = 6;
    localparam int USC_B_MCE = 5;
    localparam int USC_B_REN = 4;
    localparam int USC_B_TB8 = 3;
    localparam int USC_B_RB8 = 2;
    localparam int USC_B_TI = 1;
    localparam int USC_B_RI = 0;
    localparam logic [7:0] USC_CTRL_RESET = 8'h00;
    localparam logic [7:0] USC_MASK_RESET = 8'h00;
    localparam logic [7:0] USC_FLAG_MASK = 8'h03;
    // ------------------------------------------------------------
    // Bit timing
    // ------------------------------------------------------------
    localparam logic [15:0] USC_DIV_RESET = 16'h0364;
    localparam logic [15:0] USC_DIV_MIN = 16'h0001;
    localparam logic [3:0] USC_DATA_BITS = 4'h8;
    localparam logic [3:0] USC_ZERO4 = 4'h0;
    localparam logic [15:0] USC_ZERO16 = 16'h0000;
    // ------------------------------------------------------------
    // State codes
    // ------------------------------------------------------------
    typedef enum logic [4:0] {
        USC_TX_IDLE = 5'b0_0001,
        USC_TX_START = 5'b0_0010,
        USC_TX_DATA = 5'b0_0100,
        USC_TX_NINTH = 5'b0_1000,
        USC_TX_STOP = 5'b1_0000
    } usc_tx_e;
endpackage : usc_pkg

// ==== design/usc_rx.sv ====
/*
 Receive shifter: samples the line mid-bit and reports a whole frame.
 Assumes rx_line is synchronous to ref_clk and idles high.
*/
`timescale 1ns/1ns
`default_nettype none
module usc_rx (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic rx_line,
    input wire logic enable,
    input wire logic nine_bit,
    input wire logic [15:0] bit_div,
    output logic frame_done,
    output logic [7:0] frame_data,
    output logic frame_ninth
);
    import usc_pkg::*;

    typedef struct packed {
        logic busy;
        logic [15:0] cnt;
        logic [3:0] idx;
        logic [8:0] shift;
        logic done;
    } usc_rx_s;

    usc_rx_s s_reg, s_next;

    // ------------------------------------------------------------
    // Frame capture
    // ------------------------------------------------------------
    always_comb begin
        logic [3:0] last;
        last = nine_bit ? (USC_DATA_BITS + 4'h2) : (USC_DATA_BITS + 4'h1);
        s_next = s_reg;
        s_next.done = 1'b0;
        if (!s_reg.busy) begin
            if (enable && !rx_line) begin // RULE_04
                s_next.busy = 1'b1;
                s_next.cnt = {1'b0, bit_div[15:1]};
                s_next.idx = USC_ZERO4;
            end
        end else if (s_reg.cnt != USC_ZERO16) begin
            s_next.cnt = s_reg.cnt - 16'h0001;
        end else begin
            s_next.cnt = bit_div - 16'h0001;
            if (s_reg.idx == USC_ZERO4 && rx_line) begin
                s_next.busy = 1'b0;
            end else if (s_reg.idx == last) begin
                s_next.busy = 1'b0;
                s_next.done = 1'b1;
                if (!nine_bit) begin
                    s_next.shift = {rx_line, s_reg.shift[8:1]}; // RULE_06
                end
            end else begin
                if (s_reg.idx != USC_ZERO4) begin
                    s_next.shift = {rx_line, s_reg.shift[8:1]};
                end
                s_next.idx = s_reg.idx + 4'h1;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign frame_done = s_reg.done;
    assign frame_data = s_reg.shift[7:0];
    assign frame_ninth = s_reg.shift[8];
endmodule : usc_rx
`default_nettype wire

// ==== design/usc_top.sv ====
/*
 Serial port control block: control register, data buffer, transmitter,
 frame acceptance filter and interrupt logic.
 Assumes a 100 MHz ref_clk, a synchronous rx_line, one-cycle strobes.
*/
// Operation
// RULE_01: Bit 7 selects 8-bit or 9-bit frames
// RULE_02: 8-bit filter on needs high stop
// RULE_03: 9-bit filter on needs ninth bit one
// RULE_04: Receive enable gates all reception; code checks it only at start detect, a started frame completes
// RULE_05: Ninth transmit bit sent only 9-bit
// RULE_06: Ninth receive bit takes stop or ninth
// RULE_07: Transmit done after data or ninth bit
// RULE_08: Transmit done raises interrupt, software clears
// RULE_09: Accept only while receive done clear
// RULE_10: 8-bit frame: start, eight LSB-first, stop
// RULE_11: 9-bit frame adds programmable ninth bit
// RULE_12: Data buffer write starts transmission
// RULE_13: Receive done cleared only by software
// RULE_14: Bit 6 unused, ignores writes
`timescale 1ns/1ns
`default_nettype none
module usc_top (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic rx_line,
    output logic tx_line,
    output logic irq
);
    import usc_pkg::*;

    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] rx_buf;
        logic [7:0] mask;
        logic [7:0] stat;
        logic [15:0] div;
        usc_tx_e tx_state;
        logic [15:0] tx_cnt;
        logic [3:0] tx_idx;
        logic [7:0] tx_shift;
        logic tx_ninth;
        logic tx_out;
        logic [7:0] rdata;
    } usc_s;

    usc_s s_reg, s_next;
    logic rx_done;
    logic [7:0] rx_data;
    logic rx_ninth;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic usc_accept(input logic mce, input logic ninth, input logic flag);
        // Stop bit in 8-bit mode and ninth bit in 9-bit mode share one slot
        usc_accept = !flag && (!mce || ninth); // RULE_02 RULE_03 RULE_09
    endfunction : usc_accept

    function automatic logic usc_hit(input logic [1:0] a, input logic [1:0] t);
        usc_hit = (a == t);
    endfunction : usc_hit

    usc_rx u_rx (
        .ref_clk(ref_clk),
        .rst(rst),
        .rx_line(rx_line),
        .enable(s_reg.ctrl[USC_B_REN]),
        .nine_bit(s_reg.ctrl[USC_B_FMT]),
        .bit_div(s_reg.div),
        .frame_done(rx_done),
        .frame_data(rx_data),
        .frame_ninth(rx_ninth)
    );

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic set_ti;
        logic set_ri;
        logic tick;
        s_next = s_reg;
        set_ti = 1'b0;
        set_ri = 1'b0;
        tick = (s_reg.tx_cnt == USC_ZERO16);
        s_next.rdata = 8'h00;
        if (!tick) begin
            s_next.tx_cnt = s_reg.tx_cnt - 16'h0001;
        end

        // Register writes
        if (reg_wr) begin
            unique case (reg_addr)
                USC_ADDR_CTRL: begin
                    s_next.ctrl = reg_wdata;
                    s_next.ctrl[USC_B_UNUSED] = 1'b0; // RULE_14
                    s_next.ctrl[USC_B_RB8] = s_reg.ctrl[USC_B_RB8];
                    // Flags can only be cleared by software
                    s_next.ctrl[USC_B_TI] = s_reg.ctrl[USC_B_TI] & reg_wdata[USC_B_TI]; // RULE_08
                    s_next.ctrl[USC_B_RI] = s_reg.ctrl[USC_B_RI] & reg_wdata[USC_B_RI]; // RULE_13
                end
                USC_ADDR_DATA: begin
                    if (s_reg.tx_state == USC_TX_IDLE) begin // RULE_12
                        s_next.tx_shift = reg_wdata;
                        s_next.tx_ninth = s_reg.ctrl[USC_B_TB8];
                        s_next.tx_state = USC_TX_START;
                        s_next.tx_out = 1'b0; // RULE_10
                        s_next.tx_cnt = s_reg.div - 16'h0001;
                    end
                end
                USC_ADDR_MASK: s_next.mask = reg_wdata & USC_FLAG_MASK;
                USC_ADDR_DIV: s_next.div = {s_reg.div[15:8], reg_wdata};
                default: ;
            endcase
        end

        // Register reads
        if (reg_rd) begin
            unique case (reg_addr)
                USC_ADDR_CTRL: s_next.rdata = s_reg.ctrl;
                USC_ADDR_DATA: s_next.rdata = s_reg.rx_buf;
                USC_ADDR_MASK: s_next.rdata = s_reg.mask;
                USC_ADDR_DIV: s_next.rdata = s_reg.stat;
                default: s_next.rdata = 8'h00;
            endcase
            if (usc_hit(reg_addr, USC_ADDR_DIV)) begin
                s_next.stat = 8'h00;
            end
        end

        // Transmitter
        if (tick) begin
            s_next.tx_cnt = s_reg.div - 16'h0001;
            unique case (s_reg.tx_state)
                USC_TX_IDLE: begin
                    // Keep the full start bit time when a data write lands now
                    if (s_next.tx_state == USC_TX_IDLE) begin
                        s_next.tx_cnt = USC_ZERO16;
                    end
                end
                USC_TX_START: begin
                    s_next.tx_state = USC_TX_DATA;
                    s_next.tx_out = s_reg.tx_shift[0];
                    s_next.tx_shift = {1'b0, s_reg.tx_shift[7:1]};
                    s_next.tx_idx = 4'h1;
                end
                USC_TX_DATA: begin
                    if (s_reg.tx_idx == USC_DATA_BITS) begin
                        if (s_reg.ctrl[USC_B_FMT]) begin // RULE_01
                            s_next.tx_state = USC_TX_NINTH;
                            s_next.tx_out = s_reg.tx_ninth; // RULE_05 RULE_11
                        end else begin
                            s_next.tx_state = USC_TX_STOP;
                            s_next.tx_out = 1'b1;
                            set_ti = 1'b1; // RULE_07
                        end
                    end else begin
                        s_next.tx_out = s_reg.tx_shift[0];
                        s_next.tx_shift = {1'b0, s_reg.tx_shift[7:1]};
                        s_next.tx_idx = s_reg.tx_idx + 4'h1;
                    end
                end
                USC_TX_NINTH: begin
                    s_next.tx_state = USC_TX_STOP;
                    s_next.tx_out = 1'b1;
                    set_ti = 1'b1; // RULE_07
                end
                USC_TX_STOP: begin
                    s_next.tx_state = USC_TX_IDLE;
                    s_next.tx_cnt = USC_ZERO16;
                end
                default: begin
                    s_next.tx_state = USC_TX_IDLE;
                    s_next.tx_out = 1'b1;
                end
            endcase
        end

        // Receive acceptance
        if (rx_done && usc_accept(s_reg.ctrl[USC_B_MCE], rx_ninth, s_reg.ctrl[USC_B_RI])) begin
            s_next.rx_buf = rx_data; // RULE_09
            s_next.ctrl[USC_B_RB8] = rx_ninth; // RULE_06
            set_ri = 1'b1;
        end

        // Set wins over clear
        if (set_ti) begin
            s_next.ctrl[USC_B_TI] = 1'b1; // RULE_08
            s_next.stat[USC_B_TI] = 1'b1;
        end
        if (set_ri) begin
            s_next.ctrl[USC_B_RI] = 1'b1;
            s_next.stat[USC_B_RI] = 1'b1;
        end
        if (s_next.div == USC_ZERO16) begin
            s_next.div = USC_DIV_MIN;
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s_reg <= '0;
            s_reg.ctrl <= USC_CTRL_RESET;
            s_reg.mask <= USC_MASK_RESET;
            s_reg.div <= USC_DIV_RESET;
            s_reg.tx_state <= USC_TX_IDLE;
            s_reg.tx_out <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    assign reg_rdata = s_reg.rdata;
    assign tx_line = s_reg.tx_out;
    assign irq = |(s_reg.stat & s_reg.mask); // RULE_08
endmodule : usc_top
`default_nettype wire

// ==== test/usc_chk_sva.sv ====
/*
 Checker of the serial port control block, bound to usc_top.
 Assumes bit times below 900 clocks.
*/
`timescale 1ns/1ns
`default_nettype none
module usc_chk
    import usc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic rx_line,
    input wire logic tx_line,
    input wire logic irq
);
    localparam int IDLE = 9000;
    logic [13:0] idle_cnt;
    logic [1:0] mask_q;
    logic [1:0] mask_d;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    // ----------------
    // Helper state
    // ----------------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            idle_cnt <= 14'(IDLE);
            mask_q <= 2'b00;
        end else begin
            if (!tx_line) begin
                idle_cnt <= 14'h0000;
            end else if (idle_cnt < 14'(IDLE)) begin
                idle_cnt <= idle_cnt + 14'h0001;
            end
            if (reg_wr && reg_addr == USC_ADDR_MASK) begin
                mask_q <= reg_wdata[1:0];
            end
        end
        mask_d <= mask_q;
    end
    // ----------------
    // Properties
    // ----------------
    a_reset_rest: assert property (disable iff (1'b0)
        rst |=> tx_line && !irq && reg_rdata == 8'h00) else $error("outputs busy after reset");
    a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data without read");
    a_unused_bit: assert property (
        reg_rd && reg_addr == USC_ADDR_CTRL |=> !reg_rdata[USC_B_UNUSED]) else $error("bit 6 set");
    a_start_bit: assert property (
        reg_wr && reg_addr == USC_ADDR_DATA && idle_cnt == 14'(IDLE) |=> ##[0:1] !tx_line)
        else $error("no start bit after data write");
    a_bit_hold: assert property (
        $changed(tx_line) |=> $stable(tx_line) [*8]) else $error("short bit on tx");
    a_irq_masked: assert property (
        irq |-> (mask_q | mask_d) != 2'b00) else $error("irq while masked");
    a_status_clear: assert property (
        reg_rd && reg_addr == USC_ADDR_DIV ##2 reg_rd && reg_addr == USC_ADDR_DIV
        |=> reg_rdata == 8'h00) else $error("status not cleared by read");
    a_irq_drop: assert property (
        reg_wr && reg_addr == USC_ADDR_MASK && reg_wdata[1:0] == 2'b00 |=> ##[0:1] !irq)
        else $error("irq stays after mask off");
endmodule : usc_chk
bind usc_top usc_chk chk_u (.ref_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .rx_line, .tx_line, .irq);
`default_nettype wire

// ==== test/usc_partner.sv ====
/*
 Far serial transceiver: sends frames on rx_line, samples tx_line.
 Assumes the block's bit time is BIT clocks.
*/
`timescale 1ns/1ns
`default_nettype none
module usc_partner #(
    parameter int BIT = 768
) (
    input wire logic ref_clk,
    input wire logic tx_line,
    output var logic rx_line
);
    logic [10:0] tx_bits = 11'h000;
    int tx_cnt = 0;
    initial rx_line = 1'b1;
    task automatic send(input logic [7:0] d, input logic x, input logic nine);
        logic [10:0] f;
        f = {1'b1, x, d, 1'b0};
        for (int i = 0; i < (nine ? 11 : 10); i++) begin
            rx_line <= f[i];
            repeat (BIT) @(posedge ref_clk);
        end
        rx_line <= 1'b1;
    endtask : send
    always begin
        @(negedge tx_line);
        tx_cnt = 0;
        repeat (BIT / 2) @(posedge ref_clk);
        for (int i = 0; i < 11; i++) begin
            tx_bits[i] = tx_line;
            tx_cnt = i + 1;
            repeat (BIT) @(posedge ref_clk);
        end
    end
endmodule : usc_partner
`default_nettype wire

// ==== test/usc_tb_top.sv ====
/*
 Bench of the serial port control block: register tasks, scenarios, verdict.
 Assumes the partner model on the lines and the bound checker.
*/
`timescale 1ns/1ns
`default_nettype none
module uart_control_status_register_tb_top;
    import usc_pkg::*;
    localparam int BIT = 768;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [1:0] reg_addr = 2'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic rx_line;
    logic tx_line;
    logic irq;
    logic [7:0] v;
    int failures = 0;
    int num_checks = 0;
    int cycles = 0;
    always #5 ref_clk = ~ref_clk;
    usc_top dut_u (.ref_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .rx_line, .tx_line, .irq);
    usc_partner #(.BIT(BIT)) partner_u (.ref_clk, .tx_line, .rx_line);
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        @(posedge ref_clk);
    endtask : wr
    task automatic rd(input logic [1:0] a);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
        @(posedge ref_clk);
    endtask : rd
    task automatic test_regs();
        rd(USC_ADDR_CTRL);
        check("ctrl", v, USC_CTRL_RESET);
        rd(USC_ADDR_MASK);
        check("mask", v, USC_MASK_RESET);
        wr(USC_ADDR_CTRL, 8'hFF);
        rd(USC_ADDR_CTRL);
        check("ctrl", v, 8'hB8);
        wr(USC_ADDR_MASK, 8'h03);
        rd(USC_ADDR_MASK);
        check("mask", v, 8'h03);
        wr(USC_ADDR_DIV, 8'h00);
        wr(USC_ADDR_CTRL, 8'h00);
        $display("test regs done");
    endtask : test_regs
    task automatic test_tx(input logic [7:0] c, input logic [7:0] d, input logic n9);
        wr(USC_ADDR_CTRL, c);
        wr(USC_ADDR_DATA, d);
        wr(USC_ADDR_DATA, ~d);
        repeat (4) @(posedge ref_clk);
        wait (partner_u.tx_cnt >= 10);
        rd(USC_ADDR_CTRL);
        check("early done", {7'h00, v[USC_B_TI]}, {7'h00, !c[USC_B_FMT]});
        wait (partner_u.tx_cnt >= 11);
        rd(USC_ADDR_CTRL);
        check("done", {7'h00, v[USC_B_TI]}, 8'h01);
        check("tx data", partner_u.tx_bits[8:1], d);
        check("framing", {5'h00, partner_u.tx_bits[10:9], partner_u.tx_bits[0]},
            {5'h00, 1'b1, n9, 1'b0});
        check("irq", {7'h00, irq}, 8'h01);
        wr(USC_ADDR_MASK, 8'h01);
        check("irq", {7'h00, irq}, 8'h00);
        wr(USC_ADDR_MASK, 8'h03);
        rd(USC_ADDR_DIV);
        check("status", v, 8'h02);
        wr(USC_ADDR_CTRL, c);
        rd(USC_ADDR_CTRL);
        check("done", {7'h00, v[USC_B_TI]}, 8'h00);
        $display("test tx done");
    endtask : test_tx
    task automatic test_rx();
        logic [7:0] rc [8] = '{8'h10, 8'h11, 8'h30, 8'h10, 8'hB0, 8'hB0, 8'h90, 8'h80};
        logic [7:0] rdat [8] = '{8'h3C, 8'h55, 8'h66, 8'h0F, 8'h81, 8'hE7, 8'h42, 8'h99};
        logic [7:0] rx = 8'hA3;
        logic eri = 1'b0;
        logic erb = 1'b0;
        logic acc;
        logic [7:0] ebuf = 8'h00;
        for (int i = 0; i < 8; i++) begin
            wr(USC_ADDR_CTRL, rc[i]);
            eri = eri & rc[i][USC_B_RI];
            acc = !eri && rc[i][USC_B_REN] && (!rc[i][USC_B_MCE] || rx[i]);
            partner_u.send(rdat[i], rx[i], rc[i][USC_B_FMT]);
            repeat (8) @(posedge ref_clk);
            if (acc) begin
                eri = 1'b1;
                erb = rx[i];
                ebuf = rdat[i];
            end
            rd(USC_ADDR_CTRL);
            check("flags", {6'h00, v[USC_B_RB8], v[USC_B_RI]}, {6'h00, erb, eri});
            check("irq", {7'h00, irq}, {7'h00, acc});
            rd(USC_ADDR_DATA);
            check("buffer", v, ebuf);
            rd(USC_ADDR_DIV);
            check("status", v, {7'h00, acc});
            rd(USC_ADDR_DIV);
            check("status", v, 8'h00);
        end
        $display("test rx done");
    endtask : test_rx
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : report_and_stop
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 95000) begin
            failures++;
            report_and_stop();
        end
    end
    initial begin
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        test_regs();
        test_tx(8'h00, 8'h3A, 1'b1);
        test_rx();
        test_tx(8'h80, 8'hC4, 1'b0);
        wr(USC_ADDR_MASK, 8'h00);
        check("irq", {7'h00, irq}, 8'h00);
        report_and_stop();
    end
endmodule : uart_control_status_register_tb_top
`default_nettype wire
